// *** design/dss_drive_stop_sequencer.sv ***
/*
  dss_drive_stop_sequencer: stop sequencing, probe latching, reference
  clamping, sensor descriptor and alarm classes behind a Wishbone slave.
  Assumes synchronous inputs, a standstill flag from the power stage and a
  32-bit absolute encoder word.
*/
`timescale 1ns/10ps
`default_nettype none
module dss_drive_stop_sequencer #(
  parameter int CYC_PER_MS = dss_pkg::MS_NS / dss_pkg::CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic emergency_stop_input_i,
  input wire logic motor_standstill_i,
  input wire logic [15:0] speed_cmd_i,
  input wire logic [31:0] encoder_word_i,
  input wire logic [1:0] probe_input_i,
  input wire logic zero_pulse_i,
  input wire dss_pkg::dss_alarm_t alarm_i,
  output logic motor_current_en_o,
  output logic [15:0] speed_setpoint_o,
  output logic [4:0] alarm_class_o
);
  import dss_pkg::*;

  logic [3:0] ctrl_word;
  logic [3:0] ctrl_prev;
  logic [15:0] probe_setup_word;
  logic [15:0] ramp_decel_time_param;
  logic [15:0] quick_decel_time_param;
  logic [15:0] speed_reference_param;
  logic [15:0] torque_reference_param;
  logic [15:0] rated_speed;
  logic [15:0] rated_torque;
  logic [17:0] torque_limit;
  dss_state_t state;
  dss_state_t next_state;
  logic [32:0] decel_acc;
  logic [32:0] next_acc;
  logic [32:0] decel_span;
  logic [15:0] active_time;
  logic [3:0] cw_fall;
  logic ramp_rise;
  logic bus_req;
  logic bus_wr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [31:0] sensor_word;
  logic [3:0] sensor_idx;
  logic [1:0][31:0] pos_val;
  logic [1:0][31:0] neg_val;
  logic [1:0] pos_stored;
  logic [1:0] neg_stored;
  logic [1:0] probe_on;
  logic [1:0] trig_prev;
  logic [1:0] pos_hit;
  logic [1:0] neg_hit;

  // clamp a written value into [lo, hi]
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [17:0] hi);
    logic [15:0] r;
    r = v;
    if ({2'b00, v} > hi)
    begin
      r = hi[15:0];
    end
    if (r < lo)
    begin
      r = lo;
    end
    return r;
  endfunction

  // bus strobes and byte-lane merge; narrow registers use the low lanes
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign wr_data = {wb_sel_i[3] ? wb_dat_i[31:24] : 8'h00, wb_sel_i[2] ? wb_dat_i[23:16] : 8'h00,
                    wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign torque_limit = 18'(rated_torque) * TRQ_FACTOR;

  // single-wait-state ack, dropped the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // writable control and parameter registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_word <= 4'h0;
      probe_setup_word <= 16'h0000;
      ramp_decel_time_param <= RAMP_RST;
      quick_decel_time_param <= QUICK_RST;
      rated_speed <= RATED_SPD_RST;
      rated_torque <= RATED_TRQ_RST;
    end
    else if (bus_wr)
    begin
      case (wb_adr_i)
        ADR_CTRL: ctrl_word <= wr_data[3:0];
        ADR_PROBE: probe_setup_word <= wr_data[15:0];
        ADR_RAMP: ramp_decel_time_param <= clamp16(wr_data[15:0], TIME_MIN, 18'(TIME_MAX));
        ADR_QUICK: quick_decel_time_param <= clamp16(wr_data[15:0], TIME_MIN, 18'(TIME_MAX));
        ADR_RATED_SPD: rated_speed <= wr_data[15:0];
        ADR_RATED_TRQ: rated_torque <= wr_data[15:0];
        default: ;
      endcase
    end
  end

  // references stay inside limits even when the rated values change later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      speed_reference_param <= SPD_REF_RST;
      torque_reference_param <= TRQ_REF_RST;
    end
    else
    begin
      if (bus_wr && wb_adr_i == ADR_SPD_REF)
        speed_reference_param <= clamp16(wr_data[15:0], SPD_REF_MIN, 18'(rated_speed));
      else
        speed_reference_param <= clamp16(speed_reference_param, SPD_REF_MIN, 18'(rated_speed));
      if (bus_wr && wb_adr_i == ADR_TRQ_REF)
        torque_reference_param <= clamp16(wr_data[15:0], TRQ_REF_MIN, torque_limit);
      else
        torque_reference_param <= clamp16(torque_reference_param, TRQ_REF_MIN, torque_limit);
    end
  end

  // sensor format descriptor, fixed words, zero above word 5
  always_comb
  begin
    sensor_idx = wb_adr_i[5:2];
    case (sensor_idx)
      4'h0: sensor_word = SENS_PRELUDE;
      4'h1: sensor_word = SENS_TYPE;
      4'h2: sensor_word = SENS_RES;
      4'h3: sensor_word = SENS_SHIFT;
      4'h4: sensor_word = SENS_SHIFT;
      4'h5: sensor_word = SENS_MT_RES;
      default: sensor_word = 32'h00000000;
    endcase
  end

  // read mux; unmapped addresses read zero but still ack
  always_comb
  begin
    rd_data = 32'h00000000;
    // only 0x40..0x7f is the descriptor; higher addresses must not alias its words
    if (wb_adr_i[7:6] == ADR_SENSOR_BASE[7:6])
      rd_data = sensor_word;
    else
    begin
      case (wb_adr_i)
        ADR_CTRL: rd_data = {28'h0000000, ctrl_word};
        ADR_PROBE: rd_data = {16'h0000, probe_setup_word};
        ADR_RAMP: rd_data = {16'h0000, ramp_decel_time_param};
        ADR_QUICK: rd_data = {16'h0000, quick_decel_time_param};
        ADR_SPD_REF: rd_data = {16'h0000, speed_reference_param};
        ADR_TRQ_REF: rd_data = {16'h0000, torque_reference_param};
        ADR_RATED_SPD: rd_data = {16'h0000, rated_speed};
        ADR_RATED_TRQ: rd_data = {16'h0000, rated_torque};
        ADR_STATUS: rd_data = {speed_setpoint_o, 3'h0, alarm_class_o, 3'h0, motor_current_en_o, 1'b0, state};
        ADR_PROBE_STAT: rd_data = {16'h0000, 5'h00, neg_stored[1], pos_stored[1], probe_on[1],
                                   5'h00, neg_stored[0], pos_stored[0], probe_on[0]};
        ADR_LATCH_BASE: rd_data = pos_val[0];
        ADR_LATCH_BASE + 8'h04: rd_data = neg_val[0];
        ADR_LATCH_BASE + 8'h08: rd_data = pos_val[1];
        ADR_LATCH_BASE + 8'h0c: rd_data = neg_val[1];
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  // stop requests are falling edges of the control word
  assign cw_fall = ctrl_prev & ~ctrl_word;
  assign ramp_rise = ~ctrl_prev[CW_RAMP] & ctrl_word[CW_RAMP];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_prev <= 4'h0;
    else
      ctrl_prev <= ctrl_word;
  end

  // stop sequence; emergency and coast win over every deceleration
  always_comb
  begin
    next_state = state;
    case (state)
      ST_INHIBIT:
        if (!emergency_stop_input_i && !ctrl_word[CW_RAMP] && ctrl_word[CW_COAST] && ctrl_word[CW_QUICK])
          next_state = ST_READY;
      ST_READY:
        if (emergency_stop_input_i || !ctrl_word[CW_COAST] || !ctrl_word[CW_QUICK])
          next_state = ST_INHIBIT;
        else if (ramp_rise && ctrl_word[CW_OPER])
          next_state = ST_RUN;
      ST_RUN:
        if (emergency_stop_input_i || cw_fall[CW_COAST])
          next_state = ST_COAST;
        else if (cw_fall[CW_QUICK])
          next_state = ST_QUICK;
        else if (cw_fall[CW_RAMP])
          next_state = ST_RAMP;
      ST_RAMP:
        if (emergency_stop_input_i || cw_fall[CW_COAST])
          next_state = ST_COAST;
        else if (cw_fall[CW_QUICK])
          next_state = ST_QUICK;
        else if (cw_fall[CW_OPER] || speed_setpoint_o == 16'h0000)
          next_state = ST_READY;
      ST_QUICK:
        if (emergency_stop_input_i || cw_fall[CW_COAST])
          next_state = ST_COAST;
        else if (cw_fall[CW_OPER] || speed_setpoint_o == 16'h0000)
          next_state = ST_READY;
      ST_COAST:
        if (motor_standstill_i)
          next_state = ST_INHIBIT;
      default: next_state = ST_INHIBIT;
    endcase
  end

  // current enable follows the next state so a cut lands on the same edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_INHIBIT;
      motor_current_en_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      motor_current_en_o <= next_state == ST_RUN || next_state == ST_RAMP || next_state == ST_QUICK;
    end
  end

  // one rpm step each time the accumulator passes time x cycles-per-ms;
  // this spreads rated speed over the whole time without a divider;
  // limitation: one step per clock, so time x cycles-per-ms must reach rated speed
  assign active_time = state == ST_QUICK ? quick_decel_time_param : ramp_decel_time_param;
  assign decel_span = 33'(active_time) * 33'(CYC_PER_MS);
  assign next_acc = decel_acc + 33'(rated_speed);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      decel_acc <= 33'h000000000;
      speed_setpoint_o <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          decel_acc <= 33'h000000000;
          speed_setpoint_o <= speed_cmd_i > rated_speed ? rated_speed : speed_cmd_i;
        end
        ST_RAMP, ST_QUICK:
          if (speed_setpoint_o != 16'h0000)
          begin
            if (next_acc >= decel_span)
            begin
              decel_acc <= next_acc - decel_span;
              speed_setpoint_o <= speed_setpoint_o - 16'h0001;
            end
            else
              decel_acc <= next_acc;
          end
        default:
        begin
          decel_acc <= 33'h000000000;
          speed_setpoint_o <= 16'h0000;
        end
      endcase
    end
  end

  // alarm classes; fieldbus first since it stops all supervision
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alarm_class_o <= CLS_NONE;
    else if (alarm_i.fieldbus_fail)
      alarm_class_o <= CLS_BUS;
    else if (alarm_i.encoder_fail)
      alarm_class_o <= CLS_ENC;
    else if (alarm_i.limit_exceeded)
      alarm_class_o <= CLS_APP;
    else if (alarm_i.hw_fault)
      alarm_class_o <= CLS_HW;
    else
      alarm_class_o <= CLS_NONE;
  end

  // touch probes; only armed while the motor carries current
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : gen_probe
      logic trig;
      logic en_bit;
      logic cont;
      assign en_bit = probe_setup_word[gi*PB_STRIDE + PB_EN];
      assign cont = probe_setup_word[gi*PB_STRIDE + PB_CONT];
      assign trig = probe_setup_word[gi*PB_STRIDE + PB_ZSEL] ? zero_pulse_i : probe_input_i[gi];
      assign pos_hit[gi] = probe_on[gi] && motor_current_en_o && trig && !trig_prev[gi] &&
                           probe_setup_word[gi*PB_STRIDE + PB_POS] && (cont || !pos_stored[gi]);
      assign neg_hit[gi] = probe_on[gi] && motor_current_en_o && !trig && trig_prev[gi] &&
                           probe_setup_word[gi*PB_STRIDE + PB_NEG] && (cont || !neg_stored[gi]);
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          probe_on[gi] <= 1'b0;
          trig_prev[gi] <= 1'b0;
          pos_stored[gi] <= 1'b0;
          neg_stored[gi] <= 1'b0;
          pos_val[gi] <= 32'h00000000;
          neg_val[gi] <= 32'h00000000;
        end
        else
        begin
          trig_prev[gi] <= trig;
          probe_on[gi] <= en_bit;
          if (en_bit && !probe_on[gi])
          begin
            pos_stored[gi] <= 1'b0;
            neg_stored[gi] <= 1'b0;
          end
          else
          begin
            if (pos_hit[gi])
            begin
              pos_val[gi] <= encoder_word_i;
              pos_stored[gi] <= 1'b1;
            end
            if (neg_hit[gi])
            begin
              neg_val[gi] <= encoder_word_i;
              neg_stored[gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_emg_cut;
    emergency_stop_input_i && (state == ST_RUN || state == ST_RAMP || state == ST_QUICK)
      |=> !motor_current_en_o && state == ST_COAST;
  endproperty
  a_emg_cut: assert property (p_emg_cut) else $error("emergency did not cut current");

  property p_coast_cut;
    state == ST_RUN && cw_fall[CW_COAST] |=> !motor_current_en_o ##1 !motor_current_en_o;
  endproperty
  a_coast_cut: assert property (p_coast_cut) else $error("coast stop kept current");

  property p_ramp_start;
    state == ST_RUN && cw_fall == 4'h1 && !emergency_stop_input_i |=> state == ST_RAMP && motor_current_en_o;
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp stop not started");

  property p_ramp_coast;
    state == ST_RAMP && cw_fall[CW_COAST] |=> state == ST_COAST && !motor_current_en_o;
  endproperty
  a_ramp_coast: assert property (p_ramp_coast) else $error("ramp not abandoned to coast");

  property p_ramp_quick;
    state == ST_RAMP && !emergency_stop_input_i && !cw_fall[CW_COAST] && cw_fall[CW_QUICK]
      |=> state == ST_QUICK && speed_setpoint_o <= $past(speed_setpoint_o);
  endproperty
  a_ramp_quick: assert property (p_ramp_quick) else $error("quick stop not taken");

  property p_ramp_done;
    state == ST_RAMP && speed_setpoint_o == 16'h0000 && !emergency_stop_input_i && cw_fall == 4'h0
      |=> state == ST_READY ##1 !motor_current_en_o;
  endproperty
  a_ramp_done: assert property (p_ramp_done) else $error("finished ramp did not reach ready");

  property p_decel_step;
    (state == ST_RAMP || state == ST_QUICK) && next_state == state
      |=> speed_setpoint_o == $past(speed_setpoint_o) || speed_setpoint_o == $past(speed_setpoint_o) - 16'h0001;
  endproperty
  a_decel_step: assert property (p_decel_step) else $error("setpoint not ramping linearly");

  property p_spd_clamp;
    !rst_i |=> speed_reference_param <= $past(rated_speed) && speed_reference_param >= SPD_REF_MIN
      || $past(rated_speed) < SPD_REF_MIN;
  endproperty
  a_spd_clamp: assert property (p_spd_clamp) else $error("speed reference out of range");

  property p_trq_clamp;
    !rst_i |=> 18'(torque_reference_param) <= $past(torque_limit) || $past(torque_limit) == 18'h00000;
  endproperty
  a_trq_clamp: assert property (p_trq_clamp) else $error("torque reference above limit");

  property p_probe_hold;
    !pos_hit[0] |=> pos_val[0] == $past(pos_val[0]);
  endproperty
  a_probe_hold: assert property (p_probe_hold) else $error("latched value changed without trigger");

  property p_class_bus;
    alarm_i.fieldbus_fail |=> alarm_class_o == CLS_BUS;
  endproperty
  a_class_bus: assert property (p_class_bus) else $error("fieldbus alarm class wrong");

  property p_class_enc;
    alarm_i.encoder_fail && !alarm_i.fieldbus_fail |=> alarm_class_o == CLS_ENC;
  endproperty
  a_class_enc: assert property (p_class_enc) else $error("encoder alarm class wrong");

  property p_class_app;
    alarm_i == 4'h4 |=> alarm_class_o == CLS_APP;
  endproperty
  a_class_app: assert property (p_class_app) else $error("threshold alarm class wrong");

  property p_class_range;
    alarm_i != 4'h0 |=> alarm_class_o != CLS_NONE && alarm_class_o <= CLS_MAX;
  endproperty
  a_class_range: assert property (p_class_range) else $error("alarm without a class");
endmodule // dss_drive_stop_sequencer
`default_nettype wire

// *** design/dss_pkg.sv ***
/*
  dss_pkg: shared constants and types of the drive stop sequencer.
  Assumes a single 125 MHz control clock and a 32-bit classic Wishbone bus.
*/
`default_nettype none
package dss_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PROBE = 8'h04;
  localparam logic [7:0] ADR_RAMP = 8'h08;
  localparam logic [7:0] ADR_QUICK = 8'h0c;
  localparam logic [7:0] ADR_SPD_REF = 8'h10;
  localparam logic [7:0] ADR_TRQ_REF = 8'h14;
  localparam logic [7:0] ADR_RATED_SPD = 8'h18;
  localparam logic [7:0] ADR_RATED_TRQ = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;
  localparam logic [7:0] ADR_PROBE_STAT = 8'h24;
  localparam logic [7:0] ADR_LATCH_BASE = 8'h30;
  localparam logic [7:0] ADR_SENSOR_BASE = 8'h40;
  // control word bit positions
  localparam int CW_RAMP = 0;
  localparam int CW_COAST = 1;
  localparam int CW_QUICK = 2;
  localparam int CW_OPER = 3;
  // probe setup bit positions inside one byte per probe
  localparam int PB_EN = 0;
  localparam int PB_CONT = 1;
  localparam int PB_ZSEL = 2;
  localparam int PB_POS = 4;
  localparam int PB_NEG = 5;
  localparam int PB_STRIDE = 8;
  localparam int PS_POS = 1;
  localparam int PS_NEG = 2;
  // parameter limits and reset values
  localparam logic [15:0] TIME_MIN = 16'h0001;
  localparam logic [15:0] TIME_MAX = 16'h7530; // 30000 ms
  localparam logic [15:0] RAMP_RST = 16'h03e8; // 1000 ms
  localparam logic [15:0] QUICK_RST = 16'h0064; // 100 ms
  localparam logic [15:0] SPD_REF_RST = 16'h0bb8; // 3000 rpm
  localparam logic [15:0] SPD_REF_MIN = 16'h000a; // 10 rpm
  localparam logic [15:0] TRQ_REF_RST = 16'h0fa0; // 4000 x 0.1 Nm
  localparam logic [15:0] TRQ_REF_MIN = 16'h0001;
  localparam logic [17:0] TRQ_FACTOR = 18'h00003;
  localparam logic [15:0] RATED_SPD_RST = 16'h0bb8; // plain default, motor dependent
  localparam logic [15:0] RATED_TRQ_RST = 16'h0535; // plain default, motor dependent
  // encoder word layout
  localparam int ST_BITS = 17;
  localparam int MT_BITS = 15;
  // sensor format descriptor words
  localparam logic [31:0] SENS_PRELUDE = 32'h00005111;
  localparam logic [31:0] SENS_TYPE = 32'h80000002;
  localparam logic [31:0] SENS_RES = 32'h00020000; // 131072
  localparam logic [31:0] SENS_SHIFT = 32'h00000000;
  localparam logic [31:0] SENS_MT_RES = 32'h00008000; // 32768
  // diagnostic classes
  localparam logic [4:0] CLS_NONE = 5'h00;
  localparam logic [4:0] CLS_HW = 5'h01;
  localparam logic [4:0] CLS_BUS = 5'h09;
  localparam logic [4:0] CLS_ENC = 5'h0b;
  localparam logic [4:0] CLS_APP = 5'h11;
  localparam logic [4:0] CLS_MAX = 5'h14;
  typedef enum logic [2:0] {
    ST_INHIBIT, ST_READY, ST_RUN, ST_RAMP, ST_QUICK, ST_COAST
  } dss_state_t;
  typedef struct packed {
    logic hw_fault;
    logic limit_exceeded;
    logic encoder_fail;
    logic fieldbus_fail;
  } dss_alarm_t;
endpackage
`default_nettype wire

// *** dv/dss_ctrl_model.sv ***
/*
  dss_ctrl_model: cyclic controller side, a classic Wishbone master.
  Assumes the bench calls access just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dss_ctrl_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  // idle bus at time zero
  initial
  begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end

  // hold the whole request until ack is sampled, then release; only the bench watchdog ends a hang
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    we_o <= 1'b0;
    dat_o <= ~d; // released data must not look valid
  endtask
endmodule // dss_ctrl_model
`default_nettype wire

// *** dv/drive_stop_sequencer_tb_top.sv ***
/*
  drive_stop_sequencer_tb_top: self-checking bench of the stop sequencer.
  Assumes the controller model on the bus and a short millisecond count.
*/
`timescale 1ns/10ps
`default_nettype none
module drive_stop_sequencer_tb_top;
  import dss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, we, ack, estop = 1'b0, still = 1'b0, zp = 1'b0, cur;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, enc = 32'h0;
  logic [15:0] spd = 16'd3000, setp;
  logic [1:0] probe = 2'b00;
  logic [4:0] cls;
  dss_alarm_t alarm = '0;
  int error_cnt = 0;
  int checks = 0;

  always #4 clk = ~clk;

  dss_ctrl_model u_dss_ctrl_model (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
    .adr_o(adr), .dat_o(wdat));

  dss_drive_stop_sequencer #(.CYC_PER_MS(10)) u_dss_drive_stop_sequencer (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .emergency_stop_input_i(estop), .motor_standstill_i(still),
    .speed_cmd_i(spd), .encoder_word_i(enc), .probe_input_i(probe), .zero_pulse_i(zp),
    .alarm_i(alarm), .motor_current_en_o(cur), .speed_setpoint_o(setp), .alarm_class_o(cls));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_dss_ctrl_model.access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_dss_ctrl_model.access(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // control write, then wait the two cycles the sequencer needs
  task automatic go(input logic [3:0] cw);
    wr(ADR_CTRL, {28'h0, cw});
    repeat (2) @(posedge clk);
  endtask

  task automatic stat(input logic [2:0] s, input logic c);
    logic [31:0] q;
    u_dss_ctrl_model.access(1'b0, ADR_STATUS, 32'h0, q);
    chk({27'h0, q[4:0]}, {27'h0, c, 1'b0, s});
  endtask

  task automatic t_regs;
    rd(ADR_RAMP, 32'd1000);
    rd(ADR_QUICK, 32'd100);
    rd(ADR_SPD_REF, 32'd3000);
    rd(ADR_TRQ_REF, 32'(3 * RATED_TRQ_RST)); // default 4000 lies above 3 x rated torque
    wr(ADR_RAMP, 32'h0);
    rd(ADR_RAMP, 32'd1);
    wr(ADR_QUICK, 32'd40000);
    rd(ADR_QUICK, 32'd30000);
    wr(ADR_SPD_REF, 32'd5);
    rd(ADR_SPD_REF, 32'd10);
    wr(ADR_SPD_REF, 32'd9999);
    rd(ADR_SPD_REF, 32'd3000);
    wr(ADR_RATED_SPD, 32'd2000);
    rd(ADR_SPD_REF, 32'd2000);
    wr(ADR_TRQ_REF, 32'hffff);
    rd(ADR_TRQ_REF, 32'd3999);
    rd(8'h2c, 32'h0);
    wr(ADR_RATED_SPD, 32'd3000);
    wr(ADR_RAMP, 32'd1000);
  endtask

  task automatic t_desc;
    logic [31:0] dt [6] = '{32'h5111, 32'h80000002, 32'd131072, 32'h0, 32'h0, 32'd32768};
    for (int k = 0; k < 17; k++)
      rd(ADR_SENSOR_BASE + 8'(4 * k), k < 6 ? dt[k] : 32'h0);
  endtask

  // one alarm at a time, then mixes that test the priority
  task automatic t_alarm;
    logic [3:0] ai [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf, 4'h6, 4'hc, 4'h0};
    logic [4:0] ec [8] = '{5'h09, 5'h0b, 5'h11, 5'h01, 5'h09, 5'h0b, 5'h11, 5'h00};
    for (int k = 0; k < 8; k++)
    begin
      alarm <= dss_alarm_t'(ai[k]);
      repeat (3) @(posedge clk);
      chk({27'h0, cls}, {27'h0, ec[k]});
    end
  endtask

  // stop bits dropped one at a time, as a controller would
  task automatic stop_case(input logic [3:0] a, input logic [3:0] b, input logic [2:0] s, input logic c);
    go(4'he);
    go(4'hf);
    go(a);
    go(b);
    stat(s, c);
    go(4'h6);
    still <= 1'b1;
    repeat (2) @(posedge clk);
    still <= 1'b0;
  endtask

  task automatic t_emerg;
    go(4'he);
    go(4'hf);
    estop <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, cur}, 32'h0);
    estop <= 1'b0;
    stat(ST_COAST, 1'b0);
    still <= 1'b1;
    repeat (2) @(posedge clk);
    stat(ST_INHIBIT, 1'b0);
    still <= 1'b0;
  endtask

  // rated 100 rpm: 20 ms ramp needs 200 cycles from rated, 100 from half;
  // a 10 ms quick stop from near rated needs about 100
  task automatic t_ramp;
    int n;
    int e;
    wr(ADR_RATED_SPD, 32'd100);
    wr(ADR_RAMP, 32'd20);
    wr(ADR_QUICK, 32'd10);
    for (int k = 1; k <= 3; k++)
    begin
      spd <= (k == 1) ? 16'd50 : 16'd100;
      e = (k == 2) ? 200 : 100;
      go(4'he);
      go(4'hf);
      go(4'he);
      if (k == 3)
        go(4'ha);
      n = 0;
      while (setp !== 16'h0 && n < 300)
      begin
        @(posedge clk);
        n++;
      end
      chk(32'(n + 5 >= e && n <= e + 5), 32'h1);
      stat(k == 3 ? ST_INHIBIT : ST_READY, 1'b0); // quick bit still low leaves ready
    end
  endtask

  // latch must follow each rising trigger and ignore later encoder moves
  task automatic t_probe;
    logic [31:0] v;
    go(4'he);
    go(4'hf);
    wr(ADR_PROBE, 32'h0);
    wr(ADR_PROBE, 32'h13);
    for (int k = 0; k < 3; k++)
    begin
      v = {15'(k + 3), 17'(k * 9001 + 5)};
      enc <= v;
      @(posedge clk);
      probe <= 2'b01;
      repeat (2) @(posedge clk);
      probe <= 2'b00;
      enc <= ~v;
      rd(ADR_LATCH_BASE, v);
    end
    rd(ADR_PROBE_STAT, 32'h3);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_desc;
    t_alarm;
    stop_case(4'he, 4'he, ST_RAMP, 1'b1);
    stop_case(4'he, 4'hc, ST_COAST, 1'b0);
    stop_case(4'he, 4'ha, ST_QUICK, 1'b1);
    stop_case(4'he, 4'h6, ST_READY, 1'b0);
    stop_case(4'hd, 4'hd, ST_COAST, 1'b0);
    t_emerg;
    t_ramp;
    t_probe;
    stop_test;
  end

  // watchdog, far beyond the several hundred cycles expected
  initial
  begin
    #400000;
    error_cnt++;
    stop_test;
  end
endmodule // drive_stop_sequencer_tb_top
`default_nettype wire
